// [smsc_pkg.sv]
// Constants and types shared by the STOP standby controller and the core end.
// Assumes one 100 MHz clock and an asynchronous active-low reset.
package smsc_pkg;

	// ********************************
	// Timing
	// ********************************
	localparam int CLK_PERIOD_NS = 10;
	localparam int AMP_WAIT_US   = 5;
	// Least time, rounded up
	localparam int AMP_WAIT_CYC  = (AMP_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W         = 13;
	localparam int OST_STEPS     = 5;

	// ********************************
	// Encodings
	// ********************************
	localparam logic [1:0] CLK_SRC_IHS  = 2'h0;
	localparam logic [1:0] CLK_SRC_XTAL = 2'h1;
	localparam logic [1:0] CLK_SRC_EXT  = 2'h2;
	localparam logic [1:0] CLK_SRC_SUB  = 2'h3;
	localparam logic [2:0] H1_SEL_LS    = 3'h5;
	localparam logic [2:0] H1_SEL_LS7   = 3'h6;
	localparam logic [2:0] H1_SEL_LS9   = 3'h7;
	localparam logic [2:0] OST_SEL_MAX  = 3'h4;

	// ********************************
	// Reset values
	// ********************************
	localparam logic [OST_STEPS-1:0] OST_RST = 5'h00;
	localparam logic                 LS_RST  = 1'b1;

	typedef enum logic [4:0] {
		SMSC_RUN  = 5'b00001,
		SMSC_STOP = 5'b00010,
		SMSC_HALT = 5'b00100,
		SMSC_STAB = 5'b01000,
		SMSC_AMPW = 5'b10000
	} smsc_dev_e;

	typedef enum logic [5:0] {
		SMSC_C_IDLE  = 6'b000001,
		SMSC_C_LSOFF = 6'b000010,
		SMSC_C_SWCLK = 6'b000100,
		SMSC_C_ISSUE = 6'b001000,
		SMSC_C_WAIT  = 6'b010000,
		SMSC_C_CHK   = 6'b100000
	} smsc_cpu_e;

endpackage

// [smsc_if.sv]
// Link between the processor core and the STOP standby controller.
// Both ends run on the same clock; the testbench joins them.
`timescale 1ns/1ps
interface smsc_if #(
	parameter int N_IRQ = 8
);
	// Core to controller
	logic                  stop_exec;
	logic [1:0]            cpu_clk_sel;
	logic [N_IRQ-1:0]      irq_req;
	logic [N_IRQ-1:0]      irq_mask;
	logic                  irq_ack_en;
	logic                  high_speed_amp_bit;
	logic [2:0]            osc_stab_time_select;
	logic                  ls_osc_run_req;
	// Controller to core
	logic                  cpu_clk_en;
	logic                  in_standby;
	logic                  wake_vector;
	logic                  wake_next;
	logic                  reset_vector;
	logic [4:0]            osc_stab_counter_status;

	modport dev (
		input  stop_exec, cpu_clk_sel, irq_req, irq_mask, irq_ack_en,
		input  high_speed_amp_bit, osc_stab_time_select, ls_osc_run_req,
		output cpu_clk_en, in_standby, wake_vector, wake_next, reset_vector,
		output osc_stab_counter_status
	);

	modport cpu (
		output stop_exec, cpu_clk_sel, irq_req, irq_mask, irq_ack_en,
		output high_speed_amp_bit, osc_stab_time_select, ls_osc_run_req,
		input  cpu_clk_en, in_standby, wake_vector, wake_next, reset_vector,
		input  osc_stab_counter_status
	);
endinterface

// [smsc_dev.sv]
// STOP standby controller: entry, fallback, wake waits and clock gating.
// Assumes the core holds its configuration stable while it issues a stop.
// How it works
// R1: Stop accepted only on main clock
// R2: Pending unmasked interrupt cancels standby immediately
// R3: That case falls back to halt
// R4: Fallback resumes after selected stabilization wait
// R5: CPU clock gated during stop
// R6: RAM and port latches retained
// R7: Regulator in low current during stop
// R8: Timer A runs only on pin clock
// R9: Timer B runs only on pin clock
// R10: H1 runs only on low-speed clocks
// R11: Watchdog clock stops if low-speed stoppable
// R12: Async serial needs running timer A clock
// R13: Clocked serial needs external clock
// R14: Low-speed oscillator keeps pre-stop state
// R15: Software stops low-speed oscillator before stop
// R16: Software restarts halted peripherals after wake
// R17: Switch to internal clock before stop; code switches only for the crystal with fast wake requested
// R18: Check stabilization status before crystal switch
// R19: Amp bit adds 5 us resume wait; code omits it when the crystal is the CPU clock
// R20: Unmasked interrupt releases, then vector or next
// R21: Reset releases stop to reset vector
`timescale 1ns/1ps
module smsc_dev
	import smsc_pkg::*;
#(
	parameter int STAB_BASE_CYC = 256
) (
	input  wire logic  clk,
	input  wire logic  rst_n,
	smsc_if.dev        bus,
	input  wire logic  ls_sw_stoppable,
	input  wire logic  timer_a_clk_is_pin,
	input  wire logic  timer_b_clk_is_pin,
	input  wire logic  [2:0] timer_h1_clk_sel,
	input  wire logic  uart_clk_is_timer_a,
	input  wire logic  csi_clk_is_ext,
	output logic       main_osc_en,
	output logic       osc_6mhz_en,
	output logic       ls_osc_en,
	output logic       regulator_low_current,
	output logic       ram_retain,
	output logic       port_latch_retain,
	output logic       timer00_clk_en,
	output logic       timer_a_clk_en,
	output logic       timer_b_clk_en,
	output logic       timer_h1_clk_en,
	output logic       wdt_clk_en,
	output logic       uart_clk_en,
	output logic       csi_clk_en
);
	import smsc_pkg::*;

	generate
		if (STAB_BASE_CYC < 1 || STAB_BASE_CYC > 256)
		begin : g_bad_base
			$error("STAB_BASE_CYC must lie in 1..256");
		end
	endgenerate

	localparam logic [CNT_W-1:0] BASE = CNT_W'(STAB_BASE_CYC);
	localparam logic [CNT_W-1:0] AMP_LAST = CNT_W'(AMP_WAIT_CYC - 1);

	// ********************************
	// State
	// ********************************
	smsc_dev_e               state_r;
	smsc_dev_e               state_nxt;
	logic [CNT_W-1:0]        cnt_r;
	logic [2:0]              sel_r;
	logic [1:0]              src_r;
	logic                    amp_r;
	logic                    rst_seen_r;
	logic [OST_STEPS-1:0]    ost_r;
	logic                    unmasked;
	logic                    main_clk;
	logic                    wait_done;
	logic                    resume;
	logic                    stp_nxt;
	logic                    gate_nxt;
	logic                    ls_nxt;
	logic                    ta_nxt;

	function automatic logic [CNT_W-1:0] stab_len(input logic [2:0] sel);
		logic [2:0] s;
		s = (sel > OST_SEL_MAX) ? OST_SEL_MAX : sel;
		stab_len = BASE << s;
	endfunction

	assign unmasked = |(bus.irq_req & ~bus.irq_mask);
	assign main_clk = (bus.cpu_clk_sel != CLK_SRC_SUB);
	assign wait_done = (cnt_r == stab_len(sel_r) - CNT_W'(1));
	assign resume = (state_r != SMSC_RUN) && (state_nxt == SMSC_RUN);

	// ********************************
	// Sequencer
	// ********************************
	always_comb
	begin
		state_nxt = state_r;
		unique case (state_r)
			SMSC_RUN:
			begin
				// R1: main clock only
				if (bus.stop_exec && main_clk)
				begin
					// R2: pending cancels standby
					// R3: fall back to halt
					state_nxt = unmasked ? SMSC_HALT : SMSC_STOP;
				end
			end
			SMSC_STOP:
			begin
				// R20: interrupt releases stop
				if (unmasked)
					state_nxt = SMSC_STAB;
			end
			SMSC_HALT, SMSC_STAB:
			begin
				// R4: full stabilization wait
				// R19: extra amp wait
				if (wait_done)
					state_nxt = (amp_r && src_r != CLK_SRC_XTAL) ? SMSC_AMPW : SMSC_RUN;
			end
			SMSC_AMPW:
			begin
				if (cnt_r == AMP_LAST)
					state_nxt = SMSC_RUN;
			end
		endcase
	end

	// R21: reset returns to run
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			state_r <= SMSC_RUN;
		else
			state_r <= state_nxt;
	end

	// Counter restarts on each state change
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			cnt_r <= '0;
		else if (state_nxt != state_r)
			cnt_r <= '0;
		else if (state_r != SMSC_RUN && state_r != SMSC_STOP)
			cnt_r <= cnt_r + CNT_W'(1);
	end

	// Settings captured at the stop instruction
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sel_r <= 3'h0;
			src_r <= CLK_SRC_IHS;
			amp_r <= 1'b0;
		end
		else if (state_r == SMSC_RUN && bus.stop_exec)
		begin
			sel_r <= bus.osc_stab_time_select;
			src_r <= bus.cpu_clk_sel;
			amp_r <= bus.high_speed_amp_bit;
		end
	end

	// Stabilization status fills as the wait passes each step
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			ost_r <= OST_RST;
		else if (state_nxt == SMSC_STOP || (state_r == SMSC_RUN && state_nxt == SMSC_HALT))
			ost_r <= OST_RST;
		else if (state_r == SMSC_STAB || state_r == SMSC_HALT)
		begin
			for (int i = 0; i < OST_STEPS; i++)
				if (cnt_r == (BASE << i) - CNT_W'(1))
					ost_r[i] <= 1'b1;
		end
	end

	// ********************************
	// Core answers
	// ********************************
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			bus.wake_vector <= 1'b0;
			bus.wake_next   <= 1'b0;
		end
		else
		begin
			// R20: vector or next instruction
			bus.wake_vector <= resume && bus.irq_ack_en;
			bus.wake_next   <= resume && !bus.irq_ack_en;
		end
	end

	// R21: one pulse after reset release
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rst_seen_r       <= 1'b0;
			bus.reset_vector <= 1'b0;
		end
		else
		begin
			rst_seen_r       <= 1'b1;
			bus.reset_vector <= !rst_seen_r;
		end
	end

	assign bus.osc_stab_counter_status = ost_r;

	// ********************************
	// Clock and power gating
	// ********************************
	assign stp_nxt  = (state_nxt == SMSC_STOP);
	// Peripherals stay gated until the oscillator is trusted again
	assign gate_nxt = stp_nxt || (state_nxt == SMSC_STAB);
	// R14: hold low-speed state in stop
	assign ls_nxt   = gate_nxt ? ls_osc_en : (bus.ls_osc_run_req || !ls_sw_stoppable);
	// R8: timer A on pin only
	assign ta_nxt   = !gate_nxt || timer_a_clk_is_pin;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			bus.cpu_clk_en        <= 1'b1;
			bus.in_standby        <= 1'b0;
			main_osc_en           <= 1'b1;
			osc_6mhz_en           <= 1'b1;
			ls_osc_en             <= LS_RST;
			regulator_low_current <= 1'b0;
			ram_retain            <= 1'b0;
			port_latch_retain     <= 1'b0;
			timer00_clk_en        <= 1'b1;
			timer_a_clk_en        <= 1'b1;
			timer_b_clk_en        <= 1'b1;
			timer_h1_clk_en       <= 1'b1;
			wdt_clk_en            <= LS_RST;
			uart_clk_en           <= 1'b1;
			csi_clk_en            <= 1'b1;
		end
		else
		begin
			// R5: no CPU clock
			bus.cpu_clk_en        <= (state_nxt == SMSC_RUN);
			bus.in_standby        <= (state_nxt != SMSC_RUN);
			main_osc_en           <= !stp_nxt;
			osc_6mhz_en           <= !stp_nxt;
			ls_osc_en             <= ls_nxt;
			// R7: low current regulator
			regulator_low_current <= stp_nxt;
			// R6: retain RAM and latches
			ram_retain            <= gate_nxt;
			port_latch_retain     <= gate_nxt;
			timer00_clk_en        <= !gate_nxt;
			timer_a_clk_en        <= ta_nxt;
			// R9: timer B on pin only
			timer_b_clk_en        <= !gate_nxt || timer_b_clk_is_pin;
			// R10: H1 low-speed selections
			timer_h1_clk_en       <= !gate_nxt || (ls_nxt && (timer_h1_clk_sel == H1_SEL_LS
				|| timer_h1_clk_sel == H1_SEL_LS7 || timer_h1_clk_sel == H1_SEL_LS9));
			// R11: watchdog on low-speed clock
			wdt_clk_en            <= ls_nxt && !(gate_nxt && ls_sw_stoppable);
			// R12: needs running timer A
			uart_clk_en           <= !gate_nxt || (uart_clk_is_timer_a && ta_nxt);
			// R13: external serial clock only
			csi_clk_en            <= !gate_nxt || csi_clk_is_ext;
		end
	end

endmodule // smsc_dev

// [smsc_cpu.sv]
// Core end: prepares clocks and the low-speed oscillator, then issues stop.
// Assumes the controller answers each accepted stop with a wake pulse.
`timescale 1ns/1ps
module smsc_cpu
	import smsc_pkg::*;
#(
	parameter int N_IRQ = 8
) (
	input  wire logic              clk,
	input  wire logic              rst_n,
	smsc_if.cpu                    bus,
	input  wire logic              usr_stop_req,
	input  wire logic [1:0]        usr_clk_sel,
	input  wire logic              usr_ls_off,
	input  wire logic              usr_fast_wake,
	input  wire logic [N_IRQ-1:0]  usr_irq_req,
	input  wire logic [N_IRQ-1:0]  usr_irq_mask,
	input  wire logic              usr_ack_en,
	input  wire logic              usr_amp,
	input  wire logic [2:0]        usr_ost_sel,
	output logic                   usr_busy,
	output logic                   usr_restart_periph,
	output logic                   usr_woke_vector,
	output logic                   usr_reset_seen
);
	import smsc_pkg::*;

	generate
		if (N_IRQ < 1)
		begin : g_bad_irq
			$error("N_IRQ must be at least 1");
		end
	endgenerate

	smsc_cpu_e   state_r;
	smsc_cpu_e   state_nxt;
	logic        ls_req_r;
	logic        sw_r;
	logic        woke;
	logic        ost_full;

	assign woke     = bus.wake_vector || bus.wake_next;
	assign ost_full = &bus.osc_stab_counter_status;

	always_comb
	begin
		state_nxt = state_r;
		unique case (state_r)
			SMSC_C_IDLE:
				if (usr_stop_req && usr_clk_sel != CLK_SRC_SUB)
					state_nxt = usr_ls_off ? SMSC_C_LSOFF : SMSC_C_SWCLK;
			// R15: oscillator off first
			SMSC_C_LSOFF:
				state_nxt = SMSC_C_SWCLK;
			SMSC_C_SWCLK:
				state_nxt = SMSC_C_ISSUE;
			SMSC_C_ISSUE:
				state_nxt = SMSC_C_WAIT;
			SMSC_C_WAIT:
				if (woke)
					state_nxt = sw_r ? SMSC_C_CHK : SMSC_C_IDLE;
			// R18: wait for full status
			SMSC_C_CHK:
				if (ost_full)
					state_nxt = SMSC_C_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			state_r <= SMSC_C_IDLE;
		else
			state_r <= state_nxt;
	end

	// R17: internal clock before stop, only for the crystal with fast wake requested
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			sw_r <= 1'b0;
		else if (state_r == SMSC_C_SWCLK)
			sw_r <= usr_fast_wake && (usr_clk_sel == CLK_SRC_XTAL);
		else if (state_r == SMSC_C_CHK && ost_full)
			sw_r <= 1'b0;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			ls_req_r <= 1'b1;
		else if (state_r == SMSC_C_LSOFF)
			ls_req_r <= 1'b0;
		else if (state_r == SMSC_C_WAIT && woke)
			ls_req_r <= 1'b1;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			usr_restart_periph <= 1'b0;
			usr_woke_vector    <= 1'b0;
			usr_reset_seen     <= 1'b0;
		end
		else
		begin
			// R16: restart after wake
			usr_restart_periph <= (state_r == SMSC_C_WAIT) && woke;
			usr_woke_vector    <= bus.wake_vector;
			usr_reset_seen     <= bus.reset_vector;
		end
	end

	assign bus.stop_exec            = (state_r == SMSC_C_ISSUE);
	assign bus.cpu_clk_sel          = sw_r ? CLK_SRC_IHS : usr_clk_sel;
	assign bus.irq_req              = usr_irq_req;
	assign bus.irq_mask             = usr_irq_mask;
	assign bus.irq_ack_en           = usr_ack_en;
	assign bus.high_speed_amp_bit   = usr_amp;
	assign bus.osc_stab_time_select = usr_ost_sel;
	assign bus.ls_osc_run_req       = ls_req_r;
	assign usr_busy                 = (state_r != SMSC_C_IDLE);

endmodule // smsc_cpu

// [smsc_chk.sv]
// Checker for the standby link between core end and controller.
// Assumes it sits beside the interface instance, on the link clock and reset.
`timescale 1ns/1ps
module smsc_chk
	import smsc_pkg::*;
#(
	parameter int STAB_BASE_CYC = 256
) (
	input wire logic       clk,
	input wire logic       rst_n,
	input wire logic       stop_exec,
	input wire logic [1:0] cpu_clk_sel,
	input wire logic       irq_ack_en,
	input wire logic       high_speed_amp_bit,
	input wire logic       cpu_clk_en,
	input wire logic       in_standby,
	input wire logic       wake_vector,
	input wire logic       wake_next,
	input wire logic       reset_vector,
	input wire logic [4:0] osc_stab_counter_status
);
	logic [15:0] stby_cnt_r;
	logic        amp_cap_r;
	logic        take;

	assign take = !in_standby && stop_exec && cpu_clk_sel != CLK_SRC_SUB;

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	// Length of the current standby stay
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			stby_cnt_r <= 16'h0000;
		else if (!in_standby)
			stby_cnt_r <= 16'h0000;
		else
			stby_cnt_r <= stby_cnt_r + 16'h0001;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			amp_cap_r <= 1'b0;
		else if (take)
			amp_cap_r <= high_speed_amp_bit && cpu_clk_sel != CLK_SRC_XTAL;
	end

	property p_take;
		take |=> in_standby && !cpu_clk_en;
	endproperty
	a_take: assert property (p_take) else $error("stop not entered");

	property p_gated;
		in_standby |-> !cpu_clk_en;
	endproperty
	a_gated: assert property (p_gated) else $error("cpu clock in standby");

	property p_stab_min;
		$fell(in_standby) |-> stby_cnt_r >= 16'(STAB_BASE_CYC);
	endproperty
	a_stab_min: assert property (p_stab_min) else $error("wake too early");

	property p_amp;
		$fell(in_standby) && amp_cap_r |-> stby_cnt_r >= 16'(STAB_BASE_CYC + AMP_WAIT_CYC);
	endproperty
	a_amp: assert property (p_amp) else $error("amp wait cut short");

	property p_wake_kind;
		$fell(in_standby) |-> cpu_clk_en && wake_vector == irq_ack_en && wake_next == !irq_ack_en;
	endproperty
	a_wake_kind: assert property (p_wake_kind) else $error("wrong wake kind");

	property p_pulse;
		wake_vector || wake_next |=> !wake_vector && !wake_next;
	endproperty
	a_pulse: assert property (p_pulse) else $error("wake pulse too long");

	property p_reset_vec;
		reset_vector |-> cpu_clk_en && !in_standby ##1 !reset_vector;
	endproperty
	a_reset_vec: assert property (p_reset_vec) else $error("bad reset vector");

	property p_stat_clr;
		$rose(in_standby) |=> osc_stab_counter_status == 5'h00;
	endproperty
	a_stat_clr: assert property (p_stat_clr) else $error("status not cleared");
endmodule // smsc_chk

// [stop_mode_standby_control_tb.sv]
// Bench joining core end and controller; random setups through the core end.
// Assumes the package constants; stabilization base shortened to 4 cycles.
`timescale 1ns/1ps
module stop_mode_standby_control_tb;
	import smsc_pkg::*;
	localparam int B = 4;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        ls_stop = 1'b0, ta_pin = 1'b0, tb_pin = 1'b0, uart_ta = 1'b0, csi_ext = 1'b0;
	logic [2:0]  h1_sel = 3'h0, usr_ost_sel = 3'h0;
	logic [1:0]  usr_clk_sel = 2'h0;
	logic        usr_stop_req = 1'b0, usr_ls_off = 1'b0, usr_fast_wake = 1'b0;
	logic        usr_ack_en = 1'b0, usr_amp = 1'b0, stby_d;
	logic [7:0]  usr_irq_req = 8'h00, usr_irq_mask = 8'h00;
	logic        usr_busy, usr_restart, usr_woke_vec, usr_rst_seen;
	logic        wake_d = 1'b0;
	logic [1:0]  kind_d = 2'b00;
	wire  [12:0] g;
	logic [25:0] q_gate[$];
	logic [1:0]  q_wake[$];
	int          errors = 0;
	int          samples_checked = 0;

	always #5 clk = ~clk;

	smsc_if #(.N_IRQ(8)) bus_if ();
	smsc_dev #(.STAB_BASE_CYC(B)) smsc_dev_inst (.clk(clk), .rst_n(rst_n), .bus(bus_if),
		.ls_sw_stoppable(ls_stop), .timer_a_clk_is_pin(ta_pin), .timer_b_clk_is_pin(tb_pin),
		.timer_h1_clk_sel(h1_sel), .uart_clk_is_timer_a(uart_ta), .csi_clk_is_ext(csi_ext),
		.main_osc_en(g[12]), .osc_6mhz_en(g[11]), .ls_osc_en(g[10]),
		.regulator_low_current(g[9]), .ram_retain(g[8]), .port_latch_retain(g[7]),
		.timer00_clk_en(g[6]), .timer_a_clk_en(g[5]), .timer_b_clk_en(g[4]),
		.timer_h1_clk_en(g[3]), .wdt_clk_en(g[2]), .uart_clk_en(g[1]), .csi_clk_en(g[0]));
	smsc_cpu #(.N_IRQ(8)) smsc_cpu_inst (.clk(clk), .rst_n(rst_n), .bus(bus_if),
		.usr_stop_req(usr_stop_req), .usr_clk_sel(usr_clk_sel), .usr_ls_off(usr_ls_off),
		.usr_fast_wake(usr_fast_wake), .usr_irq_req(usr_irq_req), .usr_irq_mask(usr_irq_mask),
		.usr_ack_en(usr_ack_en), .usr_amp(usr_amp), .usr_ost_sel(usr_ost_sel),
		.usr_busy(usr_busy), .usr_restart_periph(usr_restart), .usr_woke_vector(usr_woke_vec),
		.usr_reset_seen(usr_rst_seen));
	smsc_chk #(.STAB_BASE_CYC(B)) smsc_chk_inst (.clk(clk), .rst_n(rst_n),
		.stop_exec(bus_if.stop_exec), .cpu_clk_sel(bus_if.cpu_clk_sel),
		.irq_ack_en(bus_if.irq_ack_en), .high_speed_amp_bit(bus_if.high_speed_amp_bit),
		.cpu_clk_en(bus_if.cpu_clk_en), .in_standby(bus_if.in_standby),
		.wake_vector(bus_if.wake_vector), .wake_next(bus_if.wake_next),
		.reset_vector(bus_if.reset_vector),
		.osc_stab_counter_status(bus_if.osc_stab_counter_status));

	// ****************
	// Compare tasks
	// ****************
	task automatic fail(input string what);
		errors++;
		$display("Error at %0t: %s", $time, what);
	endtask
	task automatic chk_gate(input logic [12:0] a, input logic [25:0] n);
		samples_checked++;
		if ((a & n[25:13]) !== n[12:0])
			fail("standby enables");
	endtask
	task automatic chk_wake(input logic [1:0] a, input logic [1:0] n);
		samples_checked++;
		if (a !== n)
			fail("wake kind");
	endtask
	task automatic chk_bit(input logic a, input logic n);
		samples_checked++;
		if (a !== n)
			fail("level");
	endtask
	task automatic report_and_stop();
		$display("Checks %0d, errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Bounded wait on standby (sel 0) or busy (sel 1)
	task automatic wait_lvl(input logic sel, input logic v);
		int n;
		n = 0;
		while ((sel ? usr_busy : bus_if.in_standby) !== v && n < 9000)
		begin
			@(negedge clk);
			n++;
		end
		if (n == 9000)
		begin
			fail("timeout");
			report_and_stop();
		end
	endtask

	// ****************
	// Monitor
	// ****************
	always @(posedge clk)
	begin
		stby_d <= bus_if.in_standby;
		wake_d <= (rst_n === 1'b1) && ((bus_if.wake_vector | bus_if.wake_next) === 1'b1);
		// Core end answers one cycle after the wake pulse
		if (wake_d)
		begin
			chk_bit(usr_restart, 1'b1);
			chk_bit(usr_woke_vec, kind_d[1]);
		end
		// Outputs are unknown until the first edge in reset
		if (rst_n === 1'b1)
		begin
			if (bus_if.in_standby === 1'b1 && stby_d === 1'b0)
				if (q_gate.size() == 0)
					fail("spurious standby");
				else
					chk_gate(g, q_gate.pop_front());
			if ((bus_if.wake_vector | bus_if.wake_next) !== 1'b0)
				if (q_wake.size() == 0)
					fail("spurious wake");
				else
				begin
					kind_d <= q_wake[0];
					chk_wake({bus_if.wake_vector, bus_if.wake_next}, q_wake.pop_front());
				end
		end
	end

	// ****************
	// Scenarios
	// ****************
	task automatic run_stop(input logic [1:0] src, input logic pend, input logic rst);
		logic [31:0] r;
		logic        lsv;
		logic        xf;
		r = $urandom;
		lsv = !r[10] || !r[0];
		xf = src == CLK_SRC_XTAL && r[11];
		@(posedge clk);
		ls_stop <= r[0];
		ta_pin <= r[1];
		tb_pin <= r[2];
		h1_sel <= r[5:3];
		uart_ta <= r[6];
		csi_ext <= r[7];
		usr_clk_sel <= src;
		usr_ls_off <= r[10];
		usr_fast_wake <= r[11];
		usr_ack_en <= r[12];
		usr_amp <= r[13];
		// Full status needs the longest wait before the crystal switch-back
		usr_ost_sel <= xf ? OST_SEL_MAX : r[16:14];
		usr_irq_mask <= {r[24:18], 1'b0};
		usr_irq_req <= {r[31:25] & r[24:18], pend};
		usr_stop_req <= 1'b1;
		if (pend)
		begin
			q_gate.push_back({13'h1200, 13'h1000});
			q_wake.push_back({r[12], !r[12]});
		end
		else
			q_gate.push_back({13'h1FFF, 2'b00, lsv, 4'b1110, r[1], r[2],
				r[5:3] >= H1_SEL_LS && lsv, !r[0], r[6] && r[1], r[7]});
		@(posedge clk);
		usr_stop_req <= 1'b0;
		wait_lvl(1'b0, 1'b1);
		if (rst)
		begin
			@(posedge clk);
			rst_n <= 1'b0;
			repeat (3) @(posedge clk);
			rst_n <= 1'b1;
			@(negedge clk);
			chk_bit(bus_if.in_standby, 1'b0);
			chk_bit(bus_if.cpu_clk_en, 1'b1);
			@(negedge clk);
			chk_bit(bus_if.reset_vector, 1'b1);
			@(negedge clk);
			chk_bit(usr_rst_seen, 1'b1);
		end
		else
		begin
			if (!pend)
			begin
				repeat (4'(r[17:15]) + 4'h2) @(posedge clk);
				q_wake.push_back({r[12], !r[12]});
				usr_irq_req[0] <= 1'b1;
			end
			wait_lvl(1'b1, 1'b0);
			if (xf)
				chk_bit(&bus_if.osc_stab_counter_status, 1'b1);
		end
		@(posedge clk);
		usr_irq_req <= 8'h00;
	endtask

	initial
	begin
		void'($urandom(32'hAC8FC06B));
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		usr_clk_sel <= CLK_SRC_SUB;
		usr_stop_req <= 1'b1;
		@(posedge clk);
		usr_stop_req <= 1'b0;
		repeat (6) @(negedge clk);
		chk_bit(usr_busy, 1'b0);
		chk_bit(bus_if.in_standby, 1'b0);
		for (int i = 0; i < 12; i++)
			run_stop(2'(i % 3), i % 4 == 1, i == 6);
		if (q_wake.size() != 0)
			fail("wake missing");
		report_and_stop();
	end
endmodule // stop_mode_standby_control_tb
